// >>> rtl/debug_breakpoint_consts.vh
// register map, field positions and cause codes of the debug breakpoint unit
`ifndef DEBUG_BREAKPOINT_CONSTS_VH
`define DEBUG_BREAKPOINT_CONSTS_VH

// status-view register indices
`define DBU_THREAD_SEL_IDX      8'h13
`define DBU_REG_SEL_IDX         8'h14
`define DBU_CAUSE_IDX           8'h15
`define DBU_INFO_IDX            8'h16
`define DBU_STOP_VEC_IDX        8'h18
`define DBU_SCRATCH_BASE        8'h20
`define DBU_IBRK_ADDR_BASE      8'h30
`define DBU_IBRK_CTRL_BASE      8'h40
`define DBU_DWATCH_A_BASE       8'h50
`define DBU_DWATCH_B_BASE       8'h60
`define DBU_DWATCH_CTRL_BASE    8'h70
`define DBU_RWATCH_MASK_BASE    8'h80
`define DBU_RWATCH_VALUE_BASE   8'h90
`define DBU_RWATCH_CTRL_BASE    8'h9c

// decode masks: four-entry groups and the eight scratch words
`define DBU_GROUP4_MASK         8'hfc
`define DBU_GROUP8_MASK         8'hf8

// tile configuration view of the scratch words
`define DBU_CFG_SCRATCH_BASE    8'h20

// control register fields
`define DBU_CTRL_ENABLE_BIT     0
`define DBU_CTRL_MODE_BIT       1
`define DBU_CTRL_LOAD_BIT       2
`define DBU_CTRL_THREAD_LSB     16
`define DBU_CTRL_THREAD_MSB     23

// cause register fields
`define DBU_CAUSE_CODE_MSB      2
`define DBU_CAUSE_CODE_LSB      0
`define DBU_CAUSE_THREAD_MSB    15
`define DBU_CAUSE_THREAD_LSB    8
`define DBU_CAUSE_INDEX_MSB     17
`define DBU_CAUSE_INDEX_LSB     16

// cause codes
`define DBU_CAUSE_NONE          3'h0
`define DBU_CAUSE_HOST          3'h1
`define DBU_CAUSE_CALL          3'h2
`define DBU_CAUSE_IBREAK        3'h3
`define DBU_CAUSE_DWATCH        3'h4
`define DBU_CAUSE_RWATCH        3'h5

// reset values
`define DBU_ZERO32              32'h0000_0000
`define DBU_ZERO8               8'h00
`define DBU_ZERO5               5'h00

`endif

// >>> rtl/debug_breakpoint_unit.v
// debug breakpoint and watchpoint unit of a multithreaded processor tile
//
// Function
// RULE_01: cause field codes host, call, ibreak, dwatch, rwatch
// RULE_02: record lowest firing breakpoint index
// RULE_03: index zero for host or call causes
// RULE_04: record causing thread, zero for host
// RULE_05: info holds data address or resource id
// RULE_06: stop vector holds threads outside debug mode
// RULE_07: stopped threads stay idle after debug return
// RULE_08: writable 8-bit thread select, upper bits reserved
// RULE_09: writable 5-bit register select
// RULE_10: four instruction breakpoints on program counter
// RULE_11: mode bit picks equal or not equal
// RULE_12: breakpoint gated by enable and thread mask
// RULE_13: four data watchpoints with two addresses
// RULE_14: mode bit picks AND or OR
// RULE_15: loads trigger only when load bit set
// RULE_16: data watch gated by enable and threads
// RULE_17: four resource watchpoints with mask, value
// RULE_18: mode bit picks condition A or B
// RULE_19: resource watch gated by enable and threads
// RULE_20: eight scratch words shared with config view
// RULE_21: host sets request bit to interrupt
// RULE_22: resource id masked then compared to value
// RULE_23: data address compared to address A, B
`timescale 1ns/10ps
`include "debug_breakpoint_consts.vh"

module debug_breakpoint_unit (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // status-view register port
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [31:0] reg_wdata_i,
    output reg  [31:0] reg_rdata_o,
    // tile configuration view of the scratch words
    input  wire [7:0]  cfg_addr_i,
    input  wire        cfg_wr_i,
    input  wire        cfg_rd_i,
    input  wire [31:0] cfg_wdata_i,
    output reg  [31:0] cfg_rdata_o,
    // asynchronous host request level from the jtag side
    input  wire        host_dbg_req_i,
    // instruction issue
    input  wire        pc_valid_i,
    input  wire [31:0] pc_i,
    input  wire [2:0]  pc_thread_i,
    input  wire        debug_call_instruction_i,
    // memory operations
    input  wire        mem_valid_i,
    input  wire        mem_load_i,
    input  wire [31:0] mem_addr_i,
    input  wire [2:0]  mem_thread_i,
    // resource operations
    input  wire        res_valid_i,
    input  wire [31:0] res_id_i,
    input  wire [2:0]  res_thread_i,
    // debug mode control
    input  wire        debug_return_i,
    output wire        debug_irq_o,
    output wire        debug_mode_o,
    output wire [7:0]  thread_halt_o,
    output wire [7:0]  debug_read_core_register_thread_o,
    output wire [4:0]  debug_read_core_register_index_o
);

    reg  [7:0]  thread_sel_q;
    reg  [4:0]  reg_sel_q;
    reg  [31:0] cause_q;
    reg  [31:0] info_q;
    reg  [7:0]  stop_vec_q;
    reg  [31:0] scratch_q [0:7];
    reg  [31:0] ibrk_addr_q [0:3];
    reg  [31:0] ibrk_ctrl_q [0:3];
    reg  [31:0] dw_addr_a_q [0:3];
    reg  [31:0] dw_addr_b_q [0:3];
    reg  [31:0] dw_ctrl_q [0:3];
    reg  [31:0] rw_mask_q [0:3];
    reg  [31:0] rw_value_q [0:3];
    reg  [31:0] rw_ctrl_q [0:3];
    reg         debug_mode_q;
    reg         host_meta_q;
    reg         host_sync_q;

    wire [3:0]  ibrk_hit;
    wire [3:0]  dw_hit;
    wire [3:0]  rw_hit;

    // host request crosses from the jtag side; first flop feeds only the second
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            host_meta_q <= 1'b0;
            host_sync_q <= 1'b0;
        end else begin
            host_meta_q <= host_dbg_req_i;
            host_sync_q <= host_meta_q;
        end
    end

    // per-entry comparators
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_watch
            wire [7:0] ib_thr = ibrk_ctrl_q[k][`DBU_CTRL_THREAD_MSB:`DBU_CTRL_THREAD_LSB];
            wire [7:0] dw_thr = dw_ctrl_q[k][`DBU_CTRL_THREAD_MSB:`DBU_CTRL_THREAD_LSB];
            wire [7:0] rw_thr = rw_ctrl_q[k][`DBU_CTRL_THREAD_MSB:`DBU_CTRL_THREAD_LSB];
            wire pc_eq  = (pc_i == ibrk_addr_q[k]);
            wire pc_cond = ibrk_ctrl_q[k][`DBU_CTRL_MODE_BIT] ? ~pc_eq : pc_eq; // [RULE_11]
            wire cond_a = (mem_addr_i == dw_addr_a_q[k]); // [RULE_23]
            wire cond_b = (mem_addr_i == dw_addr_b_q[k]); // [RULE_23]
            wire dw_cond = dw_ctrl_q[k][`DBU_CTRL_MODE_BIT] ? (cond_a | cond_b)
                                                            : (cond_a & cond_b); // [RULE_14]
            // stores always qualify, loads only on request
            wire dw_kind = ~mem_load_i | dw_ctrl_q[k][`DBU_CTRL_LOAD_BIT]; // [RULE_15]
            wire rw_eq  = ((res_id_i & rw_mask_q[k]) == rw_value_q[k]); // [RULE_22]
            wire rw_cond = rw_ctrl_q[k][`DBU_CTRL_MODE_BIT] ? ~rw_eq : rw_eq; // [RULE_18]

            assign ibrk_hit[k] = pc_valid_i & ibrk_ctrl_q[k][`DBU_CTRL_ENABLE_BIT]
                               & ib_thr[pc_thread_i] & pc_cond; // [RULE_10] [RULE_12]
            assign dw_hit[k]   = mem_valid_i & dw_ctrl_q[k][`DBU_CTRL_ENABLE_BIT]
                               & dw_thr[mem_thread_i] & dw_kind & dw_cond; // [RULE_16]
            assign rw_hit[k]   = res_valid_i & rw_ctrl_q[k][`DBU_CTRL_ENABLE_BIT]
                               & rw_thr[res_thread_i] & rw_cond; // [RULE_19]
        end
    endgenerate

    // lowest set bit of a four-entry hit vector
    function [1:0] lowest;
        input [3:0] hits;
        begin
            if (hits[0])
                lowest = 2'h0;
            else if (hits[1])
                lowest = 2'h1;
            else if (hits[2])
                lowest = 2'h2;
            else
                lowest = 2'h3;
        end
    endfunction

    // event selection; nothing fires while already in debug mode
    reg         evt_fire;
    reg  [2:0]  evt_code;
    reg  [1:0]  evt_index;
    reg  [2:0]  evt_thread;
    reg         evt_info_load;
    reg  [31:0] evt_info;

    always @* begin
        evt_fire      = 1'b0;
        evt_code      = `DBU_CAUSE_NONE;
        evt_index     = 2'h0;
        evt_thread    = 3'h0;
        evt_info_load = 1'b0;
        evt_info      = mem_addr_i;
        if (!debug_mode_q) begin
            if (host_sync_q) begin
                evt_fire   = 1'b1;
                evt_code   = `DBU_CAUSE_HOST; // [RULE_01] [RULE_21]
                evt_index  = 2'h0; // [RULE_03]
                evt_thread = 3'h0; // [RULE_04]
            end else if (pc_valid_i && debug_call_instruction_i) begin
                evt_fire   = 1'b1;
                evt_code   = `DBU_CAUSE_CALL; // [RULE_01]
                evt_index  = 2'h0; // [RULE_03]
                evt_thread = pc_thread_i; // [RULE_04]
            end else if (|ibrk_hit) begin
                evt_fire   = 1'b1;
                evt_code   = `DBU_CAUSE_IBREAK; // [RULE_01]
                evt_index  = lowest(ibrk_hit); // [RULE_02]
                evt_thread = pc_thread_i; // [RULE_04]
            end else if (|dw_hit) begin
                evt_fire      = 1'b1;
                evt_code      = `DBU_CAUSE_DWATCH; // [RULE_01]
                evt_index     = lowest(dw_hit); // [RULE_02]
                evt_thread    = mem_thread_i; // [RULE_04]
                evt_info_load = 1'b1;
                evt_info      = mem_addr_i; // [RULE_05]
            end else if (|rw_hit) begin
                evt_fire      = 1'b1;
                evt_code      = `DBU_CAUSE_RWATCH; // [RULE_01]
                evt_index     = lowest(rw_hit); // [RULE_02]
                evt_thread    = res_thread_i; // [RULE_04]
                evt_info_load = 1'b1;
                evt_info      = res_id_i; // [RULE_05]
            end
        end
    end

    // address decode of the status view
    wire in_scratch = ((reg_addr_i & `DBU_GROUP8_MASK) == `DBU_SCRATCH_BASE);
    wire in_ib_addr = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_IBRK_ADDR_BASE);
    wire in_ib_ctrl = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_IBRK_CTRL_BASE);
    wire in_dw_a    = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_DWATCH_A_BASE);
    wire in_dw_b    = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_DWATCH_B_BASE);
    wire in_dw_ctrl = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_DWATCH_CTRL_BASE);
    wire in_rw_mask = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_RWATCH_MASK_BASE);
    wire in_rw_val  = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_RWATCH_VALUE_BASE);
    wire in_rw_ctrl = ((reg_addr_i & `DBU_GROUP4_MASK) == `DBU_RWATCH_CTRL_BASE);
    wire cfg_scratch = ((cfg_addr_i & `DBU_GROUP8_MASK) == `DBU_CFG_SCRATCH_BASE);
    wire [1:0] sel4  = reg_addr_i[1:0];

    // writable control bits of the three control register kinds
    wire [31:0] ctrl2_w = {8'h00, reg_wdata_i[23:16], 14'h0000, reg_wdata_i[1:0]};
    wire [31:0] ctrl3_w = {8'h00, reg_wdata_i[23:16], 13'h0000, reg_wdata_i[2:0]};

    integer i;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            thread_sel_q <= `DBU_ZERO8;
            reg_sel_q    <= `DBU_ZERO5;
            cause_q      <= `DBU_ZERO32; // [RULE_01]
            info_q       <= `DBU_ZERO32;
            stop_vec_q   <= `DBU_ZERO8;
            debug_mode_q <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                scratch_q[i] <= `DBU_ZERO32;
            for (i = 0; i < 4; i = i + 1) begin
                ibrk_addr_q[i] <= `DBU_ZERO32;
                ibrk_ctrl_q[i] <= `DBU_ZERO32; // [RULE_12]
                dw_addr_a_q[i] <= `DBU_ZERO32;
                dw_addr_b_q[i] <= `DBU_ZERO32;
                dw_ctrl_q[i]   <= `DBU_ZERO32; // [RULE_15] [RULE_16]
                rw_mask_q[i]   <= `DBU_ZERO32;
                rw_value_q[i]  <= `DBU_ZERO32;
                rw_ctrl_q[i]   <= `DBU_ZERO32; // [RULE_19]
            end
        end else begin
            // config view first so a status-view write to the same word wins
            if (cfg_wr_i && cfg_scratch)
                scratch_q[cfg_addr_i[2:0]] <= cfg_wdata_i; // [RULE_20]
            if (reg_wr_i) begin
                if (reg_addr_i == `DBU_THREAD_SEL_IDX)
                    thread_sel_q <= reg_wdata_i[7:0]; // [RULE_08]
                if (reg_addr_i == `DBU_REG_SEL_IDX)
                    reg_sel_q <= reg_wdata_i[4:0]; // [RULE_09]
                if (reg_addr_i == `DBU_CAUSE_IDX)
                    cause_q <= {14'h0000, reg_wdata_i[17:8], 5'h00, reg_wdata_i[2:0]};
                if (reg_addr_i == `DBU_INFO_IDX)
                    info_q <= reg_wdata_i;
                if (reg_addr_i == `DBU_STOP_VEC_IDX)
                    stop_vec_q <= reg_wdata_i[7:0]; // [RULE_06]
                if (in_scratch)
                    scratch_q[reg_addr_i[2:0]] <= reg_wdata_i; // [RULE_20]
                if (in_ib_addr)
                    ibrk_addr_q[sel4] <= reg_wdata_i;
                if (in_ib_ctrl)
                    ibrk_ctrl_q[sel4] <= ctrl2_w;
                if (in_dw_a)
                    dw_addr_a_q[sel4] <= reg_wdata_i; // [RULE_13]
                if (in_dw_b)
                    dw_addr_b_q[sel4] <= reg_wdata_i; // [RULE_13]
                if (in_dw_ctrl)
                    dw_ctrl_q[sel4] <= ctrl3_w;
                if (in_rw_mask)
                    rw_mask_q[sel4] <= reg_wdata_i; // [RULE_17]
                if (in_rw_val)
                    rw_value_q[sel4] <= reg_wdata_i; // [RULE_17]
                if (in_rw_ctrl)
                    rw_ctrl_q[sel4] <= ctrl2_w;
            end
            // a captured event overrides a software write to cause, and to info on watch events, in the same cycle
            if (evt_fire) begin
                debug_mode_q <= 1'b1;
                cause_q <= {14'h0000, evt_index, 5'h00, evt_thread, 5'h00, evt_code};
                if (evt_info_load)
                    info_q <= evt_info; // [RULE_05]
            end else if (debug_return_i) begin
                debug_mode_q <= 1'b0; // [RULE_07]
            end
        end
    end

    // registered read data, one cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `DBU_ZERO32;
            cfg_rdata_o <= `DBU_ZERO32;
        end else begin
            if (reg_rd_i) begin
                if (reg_addr_i == `DBU_THREAD_SEL_IDX)
                    reg_rdata_o <= {24'h00_0000, thread_sel_q}; // [RULE_08]
                else if (reg_addr_i == `DBU_REG_SEL_IDX)
                    reg_rdata_o <= {27'h000_0000, reg_sel_q};
                else if (reg_addr_i == `DBU_CAUSE_IDX)
                    reg_rdata_o <= cause_q;
                else if (reg_addr_i == `DBU_INFO_IDX)
                    reg_rdata_o <= info_q;
                else if (reg_addr_i == `DBU_STOP_VEC_IDX)
                    reg_rdata_o <= {24'h00_0000, stop_vec_q};
                else if (in_scratch)
                    reg_rdata_o <= scratch_q[reg_addr_i[2:0]];
                else if (in_ib_addr)
                    reg_rdata_o <= ibrk_addr_q[sel4];
                else if (in_ib_ctrl)
                    reg_rdata_o <= ibrk_ctrl_q[sel4];
                else if (in_dw_a)
                    reg_rdata_o <= dw_addr_a_q[sel4];
                else if (in_dw_b)
                    reg_rdata_o <= dw_addr_b_q[sel4];
                else if (in_dw_ctrl)
                    reg_rdata_o <= dw_ctrl_q[sel4];
                else if (in_rw_mask)
                    reg_rdata_o <= rw_mask_q[sel4];
                else if (in_rw_val)
                    reg_rdata_o <= rw_value_q[sel4];
                else if (in_rw_ctrl)
                    reg_rdata_o <= rw_ctrl_q[sel4];
                else
                    reg_rdata_o <= `DBU_ZERO32;
            end
            if (cfg_rd_i)
                cfg_rdata_o <= cfg_scratch ? scratch_q[cfg_addr_i[2:0]] : `DBU_ZERO32;
        end
    end

    assign debug_irq_o  = evt_fire;
    assign debug_mode_o = debug_mode_q;
    // in debug mode the whole machine is held; outside it only the stopped threads
    assign thread_halt_o = debug_mode_q ? 8'hff : stop_vec_q; // [RULE_06] [RULE_07]
    assign debug_read_core_register_thread_o = thread_sel_q;
    assign debug_read_core_register_index_o  = reg_sel_q;

endmodule // debug_breakpoint_unit

// >>> test/debug_breakpoint_unit_asserts.sv
// port checker of the debug breakpoint unit
`timescale 1ns/10ps
`include "debug_breakpoint_consts.vh"
module debug_breakpoint_unit_asserts (
    // clock and reset
    input wire        ref_clk_i,
    input wire        rst_i,
    // register ports
    input wire [7:0]  reg_addr_i,
    input wire        reg_wr_i,
    input wire [31:0] reg_wdata_i,
    input wire [7:0]  cfg_addr_i,
    input wire        cfg_rd_i,
    input wire [31:0] cfg_rdata_o,
    // events and debug mode
    input wire        pc_valid_i,
    input wire        debug_call_instruction_i,
    input wire        debug_return_i,
    input wire        debug_irq_o,
    input wire        debug_mode_o,
    input wire [7:0]  thread_halt_o,
    input wire [7:0]  debug_read_core_register_thread_o,
    input wire [4:0]  debug_read_core_register_index_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_MODE_ON: assert property (debug_irq_o |=> debug_mode_o)
        else $error("mode not entered");
    AST_CALL: assert property (
        !debug_mode_o && pc_valid_i && debug_call_instruction_i |-> debug_irq_o)
        else $error("call not taken");
    AST_NO_REENTRY: assert property (debug_mode_o |-> !debug_irq_o)
        else $error("event taken in debug mode");
    AST_HALT_ALL: assert property (debug_mode_o |-> thread_halt_o == 8'hff)
        else $error("threads run in debug mode");
    AST_MODE_HOLD: assert property (debug_mode_o && !debug_return_i |=> debug_mode_o)
        else $error("mode dropped early");
    AST_RETURN: assert property (debug_mode_o && debug_return_i |=> !debug_mode_o)
        else $error("return ignored");
    // halt vector only moves by a write, by debug entry or by debug return
    AST_HALT_STABLE: assert property (
        !debug_mode_o && !debug_irq_o && !reg_wr_i |=> $stable(thread_halt_o))
        else $error("halt vector moved");
    AST_THREAD_SEL: assert property (reg_wr_i && reg_addr_i == `DBU_THREAD_SEL_IDX |=>
        {24'h00_0000, debug_read_core_register_thread_o} == ($past(reg_wdata_i) & 32'h0000_00ff))
        else $error("thread select wrong");
    AST_REG_SEL: assert property (reg_wr_i && reg_addr_i == `DBU_REG_SEL_IDX |=>
        {27'h000_0000, debug_read_core_register_index_o} == ($past(reg_wdata_i) & 32'h0000_001f))
        else $error("register select wrong");
    AST_CFG_UNMAPPED: assert property (
        cfg_rd_i && cfg_addr_i[7:3] != 5'h04 |=> cfg_rdata_o == 32'h0000_0000)
        else $error("config read outside scratch");
endmodule // debug_breakpoint_unit_asserts

bind debug_breakpoint_unit debug_breakpoint_unit_asserts u_debug_breakpoint_unit_asserts (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_rdata_o(cfg_rdata_o), .pc_valid_i(pc_valid_i), .debug_return_i(debug_return_i),
    .debug_call_instruction_i(debug_call_instruction_i), .debug_irq_o(debug_irq_o),
    .debug_mode_o(debug_mode_o), .thread_halt_o(thread_halt_o),
    .debug_read_core_register_thread_o(debug_read_core_register_thread_o),
    .debug_read_core_register_index_o(debug_read_core_register_index_o)
);

// >>> test/pipeline_model.sv
// behavioural pipeline and host driving the unit's event inputs
`timescale 1ns/10ps
module pipeline_model (
    // clock, and the interrupt from the unit
    input  wire        ref_clk_i,
    input  wire        debug_irq_i,
    // towards the unit
    output reg         host_req_o,
    output reg         pc_valid_o,
    output reg         call_o,
    output reg         mem_valid_o,
    output reg         load_o,
    output reg         res_valid_o,
    output reg  [31:0] addr_o,
    output reg  [2:0]  thr_o
);
    initial begin
        {host_req_o, pc_valid_o, call_o, mem_valid_o, load_o, res_valid_o} = 6'h00;
        addr_o = 32'h0000_0000;
        thr_o = 3'h0;
    end
    task host(input lvl);
        begin
            @(posedge ref_clk_i);
            #2 host_req_o = lvl;
        end
    endtask
    // one op for one cycle: kind 0 pc, 1 call, 2 memory, 3 resource
    task op(input [1:0] k, input [31:0] a, input [2:0] t, input l, output hit);
        begin
            @(posedge ref_clk_i);
            #2;
            addr_o = a;
            thr_o = t;
            load_o = l;
            pc_valid_o = k < 2'h2;
            call_o = k == 2'h1;
            mem_valid_o = k == 2'h2;
            res_valid_o = k == 2'h3;
            #10 hit = debug_irq_i;
            @(posedge ref_clk_i);
            #2;
            {pc_valid_o, call_o, mem_valid_o, res_valid_o} = 4'h0;
            // released lines must not keep looking valid
            addr_o = ~a;
        end
    endtask
endmodule // pipeline_model

// >>> test/debug_breakpoint_unit_tb.sv
// self-checking bench of the debug breakpoint unit
`timescale 1ns/10ps
`include "debug_breakpoint_consts.vh"
module debug_breakpoint_unit_tb;
    reg         ref_clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [7:0]  reg_addr_i = 8'h00, cfg_addr_i = 8'h00;
    reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
    reg  [31:0] reg_wdata_i = 32'h0000_0000, cfg_wdata_i = 32'h0000_0000;
    reg         debug_return_i = 1'b0;
    wire [31:0] reg_rdata_o, cfg_rdata_o, addr;
    wire [7:0]  thread_halt_o, sel_thr;
    wire [4:0]  sel_reg;
    wire [2:0]  thr;
    wire        host, pcv, call, memv, ld, resv, debug_irq_o, debug_mode_o;
    integer     n_mismatch = 0, compares = 0, i;
    reg  [31:0] v;
    reg         hit;
    reg  [31:0] rlist = 32'h1540_709c;
    reg  [71:0] rows [0:15] = '{72'h13_ffff_ffff_0000_00ff, 72'h14_ffff_ffff_0000_001f,
        72'h15_ffff_ffff_0003_ff07, 72'h16_1234_5678_1234_5678, 72'h18_ffff_ff5a_0000_005a,
        72'h20_0bad_f00d_0bad_f00d, 72'h27_cafe_0027_cafe_0027, 72'h30_ffff_ffff_ffff_ffff,
        72'h43_ffff_ffff_00ff_0003, 72'h73_ffff_ffff_00ff_0007, 72'h9e_ffff_ffff_00ff_0003,
        72'h52_8000_0001_8000_0001, 72'h61_0000_ff00_0000_ff00, 72'h81_f0f0_0f0f_f0f0_0f0f,
        72'h93_1357_9bdf_1357_9bdf, 72'ha0_ffff_ffff_0000_0000};

    always #12.5 ref_clk_i = ~ref_clk_i;

    debug_breakpoint_unit u_debug_breakpoint_unit (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .host_dbg_req_i(host),
        .pc_valid_i(pcv), .pc_i(addr), .pc_thread_i(thr), .debug_call_instruction_i(call),
        .mem_valid_i(memv), .mem_load_i(ld), .mem_addr_i(addr), .mem_thread_i(thr),
        .res_valid_i(resv), .res_id_i(addr), .res_thread_i(thr),
        .debug_return_i(debug_return_i), .debug_irq_o(debug_irq_o),
        .debug_mode_o(debug_mode_o), .thread_halt_o(thread_halt_o),
        .debug_read_core_register_thread_o(sel_thr), .debug_read_core_register_index_o(sel_reg));

    pipeline_model u_pipeline_model (
        .ref_clk_i(ref_clk_i), .debug_irq_i(debug_irq_o), .host_req_o(host), .pc_valid_o(pcv),
        .call_o(call), .mem_valid_o(memv), .load_o(ld), .res_valid_o(resv), .addr_o(addr),
        .thr_o(thr));

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // one register access; c picks the config view, w a write
    task acc(input c, input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i);
            #2;
            cfg_addr_i = a;
            cfg_wdata_i = d;
            reg_addr_i = a;
            reg_wdata_i = d;
            {cfg_wr_i, cfg_rd_i, reg_wr_i, reg_rd_i} = {c & w, c & !w, !c & w, !c & !w};
            @(posedge ref_clk_i);
            #2;
            {cfg_wr_i, cfg_rd_i, reg_wr_i, reg_rd_i} = 4'h0;
            v = c ? cfg_rdata_o : reg_rdata_o;
        end
    endtask
    task ret;
        begin
            @(posedge ref_clk_i);
            #2 debug_return_i = 1'b1;
            @(posedge ref_clk_i);
            #2 debug_return_i = 1'b0;
            chk({24'h00_0000, thread_halt_o}, 32'h0000_0005);
        end
    endtask
    // c nonzero means a taken event with that cause word
    task ev(input [1:0] k, input [31:0] a, input [2:0] t, input l, input [31:0] c,
            input [31:0] d);
        begin
            u_pipeline_model.op(k, a, t, l, hit);
            chk({31'h0, hit}, {31'h0, c != 0});
            if (c != 0) begin
                acc(0, 0, `DBU_CAUSE_IDX, 0);
                chk(v, c);
                acc(0, 0, `DBU_INFO_IDX, 0);
                if (k > 1)
                    chk(v, d);
                ret;
            end
        end
    endtask
    task rchk;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                acc(0, 0, rlist[31 - 8 * i -: 8], 0);
                chk(v, 32'h0000_0000);
            end
            chk({23'h0, debug_mode_o, thread_halt_o}, 32'h0000_0000);
        end
    endtask
    task wrap_up;
        begin
            $display("compares %0d mismatches %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        #2 rst_i = 1'b0;
        rchk;
        $display("reset test done");
        for (i = 0; i < 16; i = i + 1) begin
            acc(0, 1, rows[i][71:64], rows[i][63:32]);
            acc(0, 0, rows[i][71:64], 0);
            chk(v, rows[i][31:0]);
        end
        for (i = 0; i < 12; i = i + 1)
            acc(0, 1, 8'(rlist[23 - 8 * (i / 4) -: 8] + i % 4), 0);
        $display("register table done");
        acc(0, 1, `DBU_STOP_VEC_IDX, 32'h0000_0005);
        acc(0, 1, 8'h31, 32'h0000_1000);
        acc(0, 1, 8'h33, 32'h0000_1000);
        acc(0, 1, 8'h41, 32'h0004_0001);
        acc(0, 1, 8'h43, 32'h0004_0001);
        ev(0, 32'h0000_1000, 1, 0, 0, 0);
        ev(0, 32'h0000_1000, 2, 0, 32'h0001_0203, 0);
        acc(0, 1, 8'h41, 0);
        acc(0, 1, 8'h43, 0);
        acc(0, 1, 8'h30, 32'h0000_2000);
        acc(0, 1, 8'h40, 32'h0001_0003);
        ev(0, 32'h0000_2000, 0, 0, 0, 0);
        ev(0, 32'h0000_2004, 0, 0, 32'h0000_0003, 0);
        acc(0, 1, 8'h40, 0);
        ev(1, 0, 4, 0, 32'h0000_0402, 0);
        acc(0, 1, 8'h52, 32'h0000_0100);
        acc(0, 1, 8'h62, 32'h0000_0100);
        acc(0, 1, 8'h72, 32'h0008_0001);
        ev(2, 32'h0000_0100, 3, 1, 0, 0);
        ev(2, 32'h0000_0100, 3, 0, 32'h0002_0304, 32'h0000_0100);
        acc(0, 1, 8'h72, 0);
        acc(0, 1, 8'h50, 32'h0000_0200);
        acc(0, 1, 8'h60, 32'h0000_0300);
        acc(0, 1, 8'h70, 32'h0001_0001);
        ev(2, 32'h0000_0200, 0, 0, 0, 0);
        acc(0, 1, 8'h70, 32'h0001_0007);
        ev(2, 32'h0000_0300, 0, 1, 32'h0000_0004, 32'h0000_0300);
        acc(0, 1, 8'h70, 0);
        acc(0, 1, 8'h83, 32'hffff_0000);
        acc(0, 1, 8'h93, 32'h1234_0000);
        acc(0, 1, 8'h9f, 32'h0020_0001);
        ev(3, 32'h1234_abcd, 4, 0, 0, 0);
        ev(3, 32'h1234_abcd, 5, 0, 32'h0003_0505, 32'h1234_abcd);
        acc(0, 1, 8'h9f, 32'h0020_0003);
        ev(3, 32'h1234_0001, 5, 0, 0, 0);
        ev(3, 32'h5555_0000, 5, 0, 32'h0003_0505, 32'h5555_0000);
        $display("event test done");
        u_pipeline_model.host(1'b1);
        repeat (4) @(posedge ref_clk_i);
        #2;
        chk({31'h0, debug_mode_o}, 32'h0000_0001);
        u_pipeline_model.host(1'b0);
        u_pipeline_model.op(1, 0, 4, 0, hit);
        chk({31'h0, hit}, 32'h0000_0000);
        acc(0, 0, `DBU_CAUSE_IDX, 0);
        chk(v, 32'h0000_0001);
        ret;
        $display("host test done");
        acc(1, 1, 8'h21, 32'h5a5a_0021);
        acc(0, 0, 8'h21, 0);
        chk(v, 32'h5a5a_0021);
        acc(1, 0, 8'h27, 0);
        chk(v, 32'hcafe_0027);
        acc(1, 0, 8'h30, 0);
        chk(v, 32'h0000_0000);
        $display("scratch test done");
        rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #2 rst_i = 1'b0;
        rchk;
        $display("second reset test done");
        wrap_up;
    end
endmodule // debug_breakpoint_unit_tb
